// ### hw/vpw_codec_regs.svh
// Timing and field constants for the pulse width symbol codec
`ifndef VPW_CODEC_REGS_SVH
`define VPW_CODEC_REGS_SVH

// Core clock period in ns and microsecond to cycle conversion
`define VPW_CLK_NS     100
`define VPW_CYC(us)    (((us) * 1000) / `VPW_CLK_NS)
`define VPW_CW         12

// Nominal symbol times
`define VPW_T_SHORT_US 64
`define VPW_T_LONG_US  128
`define VPW_T_SOF_US   200
`define VPW_T_EOF_US   280
`define VPW_T_IFS_US   20
`define VPW_T_BRK_US   240

// Receive window edges
`define VPW_TH_A_US    34
`define VPW_TH_B_US    96
`define VPW_TH_C_US    163
`define VPW_TH_D_US    239

// Filter end points, counter limits, bit positions
`define VPW_FILT_MAX   4'hF
`define VPW_FILT_MIN   4'h0
`define VPW_CNT_SAT    12'hFFF
`define VPW_CNT_ZERO   12'h000
`define VPW_BIT_LAST   3'h7
`define VPW_BIT_FIRST  3'h0

`endif

// ### hw/vpw_pkg.sv
// Types shared by the symbol codec and its receive filter
package vpw_pkg;
  `include "vpw_codec_regs.svh"

  typedef enum logic [3:0] {
    VPW_SYM_NONE  = 4'h0,
    VPW_SYM_BIT0  = 4'h1,
    VPW_SYM_BIT1  = 4'h2,
    VPW_SYM_INV   = 4'h3,
    VPW_SYM_SOF   = 4'h4,
    VPW_SYM_BREAK = 4'h5,
    VPW_SYM_EOD   = 4'h6,
    VPW_SYM_EOF   = 4'h7,
    VPW_SYM_IFS   = 4'h8,
    VPW_SYM_IDLE  = 4'h9
  } vpw_sym_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_WAIT = 4'h2,
    TX_SOF  = 4'h4,
    TX_BITS = 4'h8
  } vpw_tx_st_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } vpw_tx_req_t;

  typedef struct packed {
    logic       sym_valid;
    vpw_sym_t   sym;
    logic       byte_valid;
    logic [7:0] data;
  } vpw_rx_out_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       lvl;
  } vpw_filt_st_t;

  typedef struct packed {
    logic [1:0]         sync;
    logic               fq;
    logic [`VPW_CW-1:0] rx_cnt;
    logic               bus_idle;
    logic               eof_seen;
    logic               rx_busy;
    logic [7:0]         rx_shift;
    logic [2:0]         rx_nbits;
    vpw_rx_out_t        rx;
    logic               inv;
    logic               fast;
    logic               rx_abort;
    vpw_tx_st_t         txs;
    logic [`VPW_CW-1:0] tx_cnt;
    logic [7:0]         tx_shift;
    logic [2:0]         tx_nbits;
    logic               tx_last;
    logic               drive;
    logic               tx_take;
    logic               tx_done;
    logic               tx_err;
  } vpw_st_t;
endpackage

// ### hw/vpw_rx_filter.sv
// Saturating up/down counter filter on the synchronised bus level, with hysteresis between end points
`timescale 1ns/1ps
`include "vpw_codec_regs.svh"
module vpw_rx_filter (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic smp,
  output logic      lvl
);
  vpw_pkg::vpw_filt_st_t s_r;
  vpw_pkg::vpw_filt_st_t s_nxt;

  // ==========================================================
  // Counter walks toward the sample, level flips at end points
  always_comb begin
    s_nxt = s_r;
    if (smp && s_r.cnt != `VPW_FILT_MAX)
      s_nxt.cnt = s_r.cnt + 4'h1;
    else if (!smp && s_r.cnt != `VPW_FILT_MIN)
      s_nxt.cnt = s_r.cnt - 4'h1;
    if (s_nxt.cnt == `VPW_FILT_MAX)
      s_nxt.lvl = 1'h1; // R23
    else if (s_nxt.cnt == `VPW_FILT_MIN)
      s_nxt.lvl = 1'h0; // R23
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign lvl = s_r.lvl;
endmodule

// ### hw/vpw_symbol_codec.sv
// Pulse width symbol encoder and receive classifier
// ==========================================================
// Overview of operation
// R1 - Passive gap counts on for 20 us after EOF, 300 us total.
// R2 - Hold own SOF until the separation time after EOF expires.
// R3 - While waiting to send, resync timing to any bus rising edge.
// R4 - Accept and sync to an SOF that starts inside separation.
// R5 - Never drive a BREAK; only detect one.
// R6 - BREAK while sending aborts transmission as an error.
// R7 - BREAK while receiving sets invalid status, drops the frame.
// R8 - BREAK during fast-rate reception clears the fast enable.
// R9 - Passive beyond 300 us is idle; sending may start at once.
// R10 - One transition per bit; logic 0 is 64 passive/128 active.
// R11 - Logic 1 is 128 us passive or 64 us active.
// R12 - First bit of every byte goes out at passive level.
// R13 - BREAK is an active level lasting at least 240 us.
// R14 - SOF is a 200 us active period, sent and recognised.
// R15 - EOD is 200 us passive, becoming EOF at 280 us.
// R16 - Normalisation bits decode exactly as data bits.
// R17 - EOD, EOF, IFS and idle are measured, never driven.
// R18 - Receive windows adjoin, resolved to one clock period.
// R19 - Passive pulse: invalid, 0, 1, then EOD as length grows.
// R20 - Edge in EOF window is EOF; in later window EOF plus IFS.
// R21 - Pending send starts on rising edge after a valid EOF.
// R22 - Active pulse shorter than first threshold is invalid.
// R23 - Classify the filtered level from a saturating counter.
// R24 - Bytes go out and come in most significant bit first.
// R25 - All durations are counts of core clock periods.
`timescale 1ns/1ps
`include "vpw_codec_regs.svh"
module vpw_symbol_codec (
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire logic           bus_receive_input,
  input  vpw_pkg::vpw_tx_req_t tx_req,
  input  wire logic           fast_rx_set,
  input  wire logic           invalid_clr,
  output logic                tx_drive,
  output logic                tx_take,
  output logic                tx_done,
  output logic                tx_err,
  output vpw_pkg::vpw_rx_out_t rx_out,
  output logic                invalid_sym,
  output logic                fast_rx_enable,
  output logic                rx_abort,
  output logic                bus_idle
);
  // ==========================================================
  // Cycle counts
  localparam logic [11:0] C_SHORT = 12'(`VPW_CYC(`VPW_T_SHORT_US)); // R25
  localparam logic [11:0] C_LONG  = 12'(`VPW_CYC(`VPW_T_LONG_US));
  localparam logic [11:0] C_SOF   = 12'(`VPW_CYC(`VPW_T_SOF_US));
  localparam logic [11:0] C_EOF   = 12'(`VPW_CYC(`VPW_T_EOF_US));
  localparam logic [11:0] C_GAP   =
    12'(`VPW_CYC(`VPW_T_EOF_US + `VPW_T_IFS_US)); // R1
  localparam logic [11:0] C_BRK   = 12'(`VPW_CYC(`VPW_T_BRK_US));
  localparam logic [11:0] C_A     = 12'(`VPW_CYC(`VPW_TH_A_US));
  localparam logic [11:0] C_B     = 12'(`VPW_CYC(`VPW_TH_B_US));
  localparam logic [11:0] C_C     = 12'(`VPW_CYC(`VPW_TH_C_US));
  localparam logic [11:0] C_D     = 12'(`VPW_CYC(`VPW_TH_D_US));

  // Fast-rate reception shrinks the bit, SOF, EOD and EOF windows by four; IFS, idle and break limits are not scaled
  function automatic logic [11:0] win(input logic [11:0] c,
                                      input logic f);
    return f ? {2'h0, c[11:2]} : c;
  endfunction

  // Bit length from value and level
  function automatic logic [11:0] bit_len(input logic b,
                                          input logic act);
    if (act)
      return b ? C_SHORT : C_LONG; // R10 R11
    return b ? C_LONG : C_SHORT; // R10 R11
  endfunction

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_r;
  logic       rst_core_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync_r <= '0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'h1};
  end
  assign rst_core_n = rst_sync_r[1];

  // ==========================================================
  // State
  vpw_pkg::vpw_st_t  s_r;
  vpw_pkg::vpw_st_t  s_nxt;
  vpw_pkg::vpw_sym_t sym;
  logic              filt;
  logic              rise;
  logic              fall;
  logic              txing;

  vpw_rx_filter u_filt (
    .core_clk (core_clk),
    .rst_n    (rst_core_n),
    .smp      (s_r.sync[1]),
    .lvl      (filt)
  );

  assign rise  = filt & ~s_r.fq;
  assign fall  = ~filt & s_r.fq;
  assign txing = (s_r.txs == vpw_pkg::TX_SOF) ||
                 (s_r.txs == vpw_pkg::TX_BITS);

  always_comb begin
    s_nxt = s_r;
    sym = vpw_pkg::VPW_SYM_NONE;
    s_nxt.sync = {s_r.sync[0], bus_receive_input};
    s_nxt.fq = filt;
    s_nxt.rx.sym_valid = 1'h0;
    s_nxt.rx.byte_valid = 1'h0;
    s_nxt.rx_abort = 1'h0;
    s_nxt.tx_take = 1'h0;
    s_nxt.tx_done = 1'h0;
    s_nxt.tx_err = 1'h0;

    // Every edge restarts the pulse timer, so an SOF in the gap
    // is measured from its own edge
    if (rise || fall)
      s_nxt.rx_cnt = `VPW_CNT_ZERO; // R4 R3
    else if (s_r.rx_cnt != `VPW_CNT_SAT)
      s_nxt.rx_cnt = s_r.rx_cnt + 12'h001;

    // Pulse classification; each upper limit is the next lower one, except the IFS window, which opens at C_EOF
    if (rise) begin
      if (s_r.rx_cnt < win(C_A, s_r.fast))
        sym = vpw_pkg::VPW_SYM_INV; // R19 R18
      else if (s_r.rx_cnt < win(C_B, s_r.fast))
        sym = vpw_pkg::VPW_SYM_BIT0; // R19 R10 R16
      else if (s_r.rx_cnt < win(C_C, s_r.fast))
        sym = vpw_pkg::VPW_SYM_BIT1; // R19 R11 R16
      else if (s_r.rx_cnt >= C_EOF && s_r.rx_cnt < C_GAP)
        sym = vpw_pkg::VPW_SYM_IFS; // R20
    end else if (fall) begin
      if (s_r.rx_cnt < win(C_A, s_r.fast))
        sym = vpw_pkg::VPW_SYM_INV; // R22
      else if (s_r.rx_cnt < win(C_B, s_r.fast))
        sym = vpw_pkg::VPW_SYM_BIT1; // R11 R18
      else if (s_r.rx_cnt < win(C_C, s_r.fast))
        sym = vpw_pkg::VPW_SYM_BIT0; // R10 R18
      else if (s_r.rx_cnt < win(C_D, s_r.fast))
        sym = vpw_pkg::VPW_SYM_SOF; // R14 R18
      else if (s_r.rx_cnt < C_BRK)
        sym = vpw_pkg::VPW_SYM_INV;
    end else if (!filt) begin
      // Passive symbols are only timed, never driven
      if (s_r.rx_cnt == win(C_C, s_r.fast))
        sym = vpw_pkg::VPW_SYM_EOD; // R15 R17 R19
      else if (s_r.rx_cnt == win(C_D, s_r.fast))
        sym = vpw_pkg::VPW_SYM_EOF; // R15 R20 R17
      else if (s_r.rx_cnt == C_GAP)
        sym = vpw_pkg::VPW_SYM_IDLE; // R1 R9 R17
    end else if (s_r.rx_cnt == C_BRK) begin
      sym = vpw_pkg::VPW_SYM_BREAK; // R13
    end

    s_nxt.rx.sym = sym;
    s_nxt.rx.sym_valid = (sym != vpw_pkg::VPW_SYM_NONE);
    if (rise || fall) begin
      s_nxt.bus_idle = 1'h0;
      s_nxt.eof_seen = 1'h0;
    end
    if (invalid_clr)
      s_nxt.inv = 1'h0;
    if (fast_rx_set)
      s_nxt.fast = 1'h1;

    unique case (sym)
      vpw_pkg::VPW_SYM_BIT0, vpw_pkg::VPW_SYM_BIT1: begin
        if (s_r.rx_busy) begin
          s_nxt.rx_shift = {s_r.rx_shift[6:0],
                            sym == vpw_pkg::VPW_SYM_BIT1}; // R24
          s_nxt.rx_nbits = s_r.rx_nbits + 3'h1;
          if (s_r.rx_nbits == `VPW_BIT_LAST) begin
            s_nxt.rx.byte_valid = 1'h1;
            s_nxt.rx.data = s_nxt.rx_shift;
          end
        end
      end
      vpw_pkg::VPW_SYM_SOF: begin
        s_nxt.rx_busy = 1'h1;
        s_nxt.rx_nbits = `VPW_BIT_FIRST;
      end
      vpw_pkg::VPW_SYM_INV: begin
        if (s_r.rx_busy) begin
          s_nxt.inv = 1'h1;
          s_nxt.rx_abort = 1'h1;
        end
        s_nxt.rx_busy = 1'h0;
      end
      vpw_pkg::VPW_SYM_BREAK: begin
        if (s_r.rx_busy) begin
          s_nxt.inv = 1'h1; // R7
          s_nxt.rx_abort = 1'h1; // R7
          s_nxt.fast = 1'h0; // R8
        end
        s_nxt.rx_busy = 1'h0;
      end
      vpw_pkg::VPW_SYM_EOF: begin
        s_nxt.rx_busy = 1'h0;
        s_nxt.eof_seen = 1'h1;
      end
      vpw_pkg::VPW_SYM_IDLE: s_nxt.bus_idle = 1'h1; // R9
      default: ;
    endcase

    // Transmit sequencer
    unique case (s_r.txs)
      vpw_pkg::TX_IDLE: begin
        if (tx_req.valid)
          s_nxt.txs = vpw_pkg::TX_WAIT;
      end
      vpw_pkg::TX_WAIT: begin
        // Wait out the gap; an edge after EOF means another node
        // already saw the gap end, so join it on that edge
        if (s_r.bus_idle || (rise && s_r.eof_seen)) begin // R2 R21 R3
          s_nxt.drive = 1'h1; // R14
          s_nxt.tx_cnt = `VPW_CNT_ZERO;
          s_nxt.tx_shift = tx_req.data;
          s_nxt.tx_last = tx_req.last;
          s_nxt.tx_take = 1'h1;
          s_nxt.txs = vpw_pkg::TX_SOF;
        end
      end
      vpw_pkg::TX_SOF: begin
        if (s_r.tx_cnt == C_SOF - 12'h001) begin
          s_nxt.drive = 1'h0; // R12
          s_nxt.tx_cnt = `VPW_CNT_ZERO;
          s_nxt.tx_nbits = `VPW_BIT_FIRST;
          s_nxt.txs = vpw_pkg::TX_BITS;
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt + 12'h001;
        end
      end
      vpw_pkg::TX_BITS: begin
        if (s_r.tx_cnt ==
            bit_len(s_r.tx_shift[7], s_r.drive) - 12'h001) begin // R10 R11
          s_nxt.tx_cnt = `VPW_CNT_ZERO;
          s_nxt.drive = ~s_r.drive; // R10
          s_nxt.tx_shift = {s_r.tx_shift[6:0], 1'h0}; // R24
          s_nxt.tx_nbits = s_r.tx_nbits + 3'h1;
          if (s_r.tx_nbits == `VPW_BIT_LAST) begin
            // Last bit was active, so a new byte starts passive
            s_nxt.drive = 1'h0; // R12
            if (s_r.tx_last) begin
              s_nxt.tx_done = 1'h1; // R17
              s_nxt.txs = vpw_pkg::TX_IDLE;
            end else if (tx_req.valid) begin
              s_nxt.tx_shift = tx_req.data;
              s_nxt.tx_last = tx_req.last;
              s_nxt.tx_take = 1'h1;
            end else begin
              s_nxt.tx_err = 1'h1;
              s_nxt.txs = vpw_pkg::TX_IDLE;
            end
          end
        end else begin
          s_nxt.tx_cnt = s_r.tx_cnt + 12'h001;
        end
      end
    endcase

    if (sym == vpw_pkg::VPW_SYM_BREAK && txing) begin
      s_nxt.drive = 1'h0; // R6
      s_nxt.tx_err = 1'h1; // R6
      s_nxt.txs = vpw_pkg::TX_IDLE; // R6
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s_r <= '0;
      s_r.txs <= vpw_pkg::TX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tx_drive       = s_r.drive;
  assign tx_take        = s_r.tx_take;
  assign tx_done        = s_r.tx_done;
  assign tx_err         = s_r.tx_err;
  assign rx_out         = s_r.rx;
  assign invalid_sym    = s_r.inv;
  assign fast_rx_enable = s_r.fast;
  assign rx_abort       = s_r.rx_abort;
  assign bus_idle       = s_r.bus_idle;

  // ==========================================================
  // Checks
  logic [11:0] drv_len_r;

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n)
      drv_len_r <= `VPW_CNT_ZERO;
    else if (!s_r.drive)
      drv_len_r <= `VPW_CNT_ZERO;
    else if (drv_len_r != `VPW_CNT_SAT)
      drv_len_r <= drv_len_r + 12'h001;
  end

  sequence s_brk;
    s_r.rx.sym_valid && s_r.rx.sym == vpw_pkg::VPW_SYM_BREAK;
  endsequence

  property p_no_brk_drive;
    @(posedge core_clk) disable iff (!rst_core_n)
      drv_len_r < C_BRK;
  endproperty
  a_no_brk_drive: assert property (p_no_brk_drive) // R5
    else $error("drive held long enough to form a break");

  property p_sof_len;
    @(posedge core_clk) disable iff (!rst_core_n)
      $fell(s_r.drive) && $past(s_r.txs) == vpw_pkg::TX_SOF &&
      !s_r.tx_err |-> $past(drv_len_r) == C_SOF - 12'h001;
  endproperty
  a_sof_len: assert property (p_sof_len) // R14
    else $error("start of frame has wrong length");

  property p_bit_len;
    @(posedge core_clk) disable iff (!rst_core_n)
      $changed(s_r.drive) && $past(s_r.txs) == vpw_pkg::TX_BITS &&
      s_r.txs == vpw_pkg::TX_BITS |->
      $past(s_r.tx_cnt) ==
      bit_len($past(s_r.tx_shift[7]), $past(s_r.drive)) - 12'h001;
  endproperty
  a_bit_len: assert property (p_bit_len) // R10
    else $error("data bit has wrong length");

  property p_level_alt;
    @(posedge core_clk) disable iff (!rst_core_n)
      s_r.txs == vpw_pkg::TX_BITS |-> s_r.drive == s_r.tx_nbits[0];
  endproperty
  a_level_alt: assert property (p_level_alt) // R12
    else $error("byte does not start passive");

  property p_start_gap;
    @(posedge core_clk) disable iff (!rst_core_n)
      $rose(s_r.drive) && s_r.txs == vpw_pkg::TX_SOF |->
      $past(s_r.bus_idle) || $past(rise && s_r.eof_seen);
  endproperty
  a_start_gap: assert property (p_start_gap) // R2
    else $error("frame started before the gap ended");

  property p_brk_len;
    @(posedge core_clk) disable iff (!rst_core_n)
      s_brk |-> $past(s_r.rx_cnt) == C_BRK && $past(s_r.fq);
  endproperty
  a_brk_len: assert property (p_brk_len) // R13
    else $error("break reported at wrong active length");

  property p_brk_tx;
    @(posedge core_clk) disable iff (!rst_core_n)
      s_brk ##0 $past(txing) |->
      !s_r.drive && s_r.tx_err && s_r.txs == vpw_pkg::TX_IDLE;
  endproperty
  a_brk_tx: assert property (p_brk_tx) // R6
    else $error("break did not stop transmission");

  property p_brk_rx;
    @(posedge core_clk) disable iff (!rst_core_n)
      s_brk ##0 $past(s_r.rx_busy) |->
      s_r.inv && s_r.rx_abort && !s_r.rx_busy ##1 !s_r.rx_abort;
  endproperty
  a_brk_rx: assert property (p_brk_rx) // R7
    else $error("break did not drop the frame");

  property p_brk_fast;
    @(posedge core_clk) disable iff (!rst_core_n)
      s_brk ##0 $past(s_r.rx_busy && s_r.fast) |-> !s_r.fast;
  endproperty
  a_brk_fast: assert property (p_brk_fast) // R8
    else $error("break left fast reception enabled");
endmodule

// ### tb/vpw_bus_node.sv
// Model of a remote bus node seen through the analogue transceiver
`timescale 1ns/1ps
module vpw_bus_node (
  input  wire logic core_clk,
  input  wire logic tx_drive,
  output logic      bus_level
);
  logic node_act;

  // ==========================================================
  // Wired bus
  // Active dominates; the pull-down makes a released bus passive
  assign bus_level = tx_drive | node_act;

  initial node_act = 1'b0;

  // ==========================================================
  // Symbol drivers
  // Level is set at an edge and held for exactly cyc clock periods
  task automatic hold(input logic act, input int cyc);
    @(posedge core_clk);
    node_act <= act;
    repeat (cyc - 1) @(posedge core_clk);
  endtask

  // Levels alternate per bit and every byte opens passive
  task automatic send_byte(input logic [7:0] d);
    logic act;
    for (int i = 7; i >= 0; i--) begin
      act = ((7 - i) % 2) == 1;
      hold(act, (d[i] ^ act) ? 1280 : 640);
    end
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the pulse width symbol codec
`timescale 1ns/1ps
module tb_top;
  logic                 core_clk;
  logic                 rst_n;
  logic                 bus_level;
  vpw_pkg::vpw_tx_req_t tx_req;
  logic                 fast_rx_set;
  logic                 invalid_clr;
  logic                 tx_drive;
  logic                 tx_take;
  logic                 tx_done;
  logic                 tx_err;
  vpw_pkg::vpw_rx_out_t rx_out;
  logic                 invalid_sym;
  logic                 fast_rx_enable;
  logic                 rx_abort;
  logic                 bus_idle;
  int                   n_mismatch = 0;
  int                   checked = 0;
  int                   cyc = 0;
  int                   n_abort = 0;
  int                   n_err = 0;
  int                   act_run = 0;
  vpw_pkg::vpw_sym_t    sym_q[$];
  vpw_pkg::vpw_sym_t    exp_q[$];
  logic [7:0]           byte_q[$];

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  vpw_symbol_codec u_vpw_symbol_codec (
    .core_clk(core_clk), .rst_n(rst_n), .bus_receive_input(bus_level),
    .tx_req(tx_req), .fast_rx_set(fast_rx_set), .invalid_clr(invalid_clr),
    .tx_drive(tx_drive), .tx_take(tx_take), .tx_done(tx_done),
    .tx_err(tx_err), .rx_out(rx_out), .invalid_sym(invalid_sym),
    .fast_rx_enable(fast_rx_enable), .rx_abort(rx_abort),
    .bus_idle(bus_idle));

  vpw_bus_node u_vpw_bus_node (
    .core_clk(core_clk), .tx_drive(tx_drive), .bus_level(bus_level));

  // ==========================================================
  // Monitor
  // Registered pulses are read once, at the edge that ends them
  always @(posedge core_clk) begin
    cyc++;
    if (rx_out.sym_valid === 1'b1) sym_q.push_back(rx_out.sym);
    if (rx_out.byte_valid === 1'b1) byte_q.push_back(rx_out.data);
    if (rx_abort === 1'b1) n_abort++;
    if (tx_err === 1'b1) n_err++;
    act_run = (tx_drive === 1'b1) ? act_run + 1 : 0;
    if (act_run == 2390) chk_len("tx active run", 0, act_run);
    if (cyc == 98000) begin
      chk_len("cycle ceiling", 0, cyc);
      stop_test();
    end
  end

  // ==========================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk_len(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk_val(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_sym(input string nm, input vpw_pkg::vpw_sym_t e,
                         input vpw_pkg::vpw_sym_t g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic run_len(output int n);
    logic l;
    l = tx_drive;
    n = 0;
    while (tx_drive === l && n < 3000) begin
      tick(1);
      n++;
    end
  endtask

  task automatic exp_byte(input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      exp_q.push_back(d[i] ? vpw_pkg::VPW_SYM_BIT1 : vpw_pkg::VPW_SYM_BIT0);
  endtask

  // Symbols are compared from the first SOF the receiver reported
  task automatic chk_seq;
    int b;
    b = 0;
    while (b < sym_q.size() && sym_q[b] !== vpw_pkg::VPW_SYM_SOF) b++;
    foreach (exp_q[k])
      chk_sym("rx symbol", exp_q[k], (b + k < sym_q.size()) ?
              sym_q[b + k] : vpw_pkg::VPW_SYM_NONE);
  endtask

  task automatic start_rx;
    int n;
    wait_hi(bus_idle, 4000, n);
    sym_q.delete();
    byte_q.delete();
    exp_q = {vpw_pkg::VPW_SYM_SOF};
  endtask

  task automatic pulse_clr;
    @(posedge core_clk);
    invalid_clr <= 1'b1;
    @(posedge core_clk);
    invalid_clr <= 1'b0;
    tick(2);
  endtask

  task automatic start_tx(input logic [7:0] d, input logic lst,
                          output int n);
    @(posedge core_clk);
    tx_req <= '{valid: 1'b1, data: d, last: lst};
    wait_hi(tx_take, 4000, n);
    @(posedge core_clk);
    tx_req.valid <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    int n;
    tick(12);
    chk_val("outputs in reset", 8'h00, {tx_drive, tx_take, tx_done, tx_err,
            invalid_sym, fast_rx_enable, rx_abort, bus_idle});
    @(posedge core_clk);
    rst_n <= 1'b1;
    wait_hi(bus_idle, 3200, n);
    chk_val("idle delay", 8'h01, {7'h0, n >= 3000 && n <= 3040});
  endtask

  task automatic t_rx_frame;
    start_rx();
    u_vpw_bus_node.hold(1'b1, 2000);
    u_vpw_bus_node.send_byte(8'hA5);
    u_vpw_bus_node.hold(1'b0, 3200);
    exp_byte(8'hA5);
    exp_q.push_back(vpw_pkg::VPW_SYM_EOD);
    exp_q.push_back(vpw_pkg::VPW_SYM_EOF);
    exp_q.push_back(vpw_pkg::VPW_SYM_IDLE);
    chk_seq();
    chk_val("rx byte", 8'hA5, byte_q.size() > 0 ? byte_q[0] : 8'h00);
  endtask

  task automatic t_rx_short;
    int a0;
    start_rx();
    a0 = n_abort;
    u_vpw_bus_node.hold(1'b1, 2000);
    u_vpw_bus_node.hold(1'b0, 640);
    u_vpw_bus_node.hold(1'b1, 200);
    u_vpw_bus_node.hold(1'b0, 400);
    exp_q.push_back(vpw_pkg::VPW_SYM_BIT0);
    exp_q.push_back(vpw_pkg::VPW_SYM_INV);
    chk_seq();
    chk_val("invalid flag", 8'h01, {7'h0, invalid_sym});
    chk_len("abort count", a0 + 1, n_abort);
    pulse_clr();
    chk_val("invalid cleared", 8'h00, {7'h0, invalid_sym});
  endtask

  task automatic t_fast_break;
    int a0;
    @(posedge core_clk);
    fast_rx_set <= 1'b1;
    @(posedge core_clk);
    fast_rx_set <= 1'b0;
    tick(2);
    chk_val("fast enable set", 8'h01, {7'h0, fast_rx_enable});
    start_rx();
    a0 = n_abort;
    u_vpw_bus_node.hold(1'b1, 500);
    u_vpw_bus_node.hold(1'b0, 160);
    u_vpw_bus_node.hold(1'b1, 2600);
    u_vpw_bus_node.hold(1'b0, 100);
    exp_q.push_back(vpw_pkg::VPW_SYM_BIT0);
    exp_q.push_back(vpw_pkg::VPW_SYM_BREAK);
    chk_seq();
    chk_val("fast enable after break", 8'h00, {7'h0, fast_rx_enable});
    chk_val("invalid after break", 8'h01, {7'h0, invalid_sym});
    chk_len("abort after break", a0 + 1, n_abort);
    pulse_clr();
  endtask

  task automatic t_tx_frame;
    int n;
    logic act;
    start_rx();
    start_tx(8'h5A, 1'b1, n);
    run_len(n);
    chk_len("tx sof length", 2000, n + 1);
    for (int i = 7; i >= 0; i--) begin
      act = ((7 - i) % 2) == 1;
      chk_val("tx bit level", {7'h0, act}, {7'h0, tx_drive});
      run_len(n);
      chk_len("tx bit length", (tx_req.data[i] ^ act) ? 1280 : 640, n);
    end
    wait_hi(tx_done, 20, n);
    chk_val("tx done", 8'h01, {7'h0, tx_done});
    tick(40);
    chk_val("own byte seen", 8'h5A, byte_q.size() > 0 ? byte_q[0] : 8'h00);
  endtask

  // A byte not marked last with nothing queued behind it must end in error
  task automatic t_tx_underrun;
    int n;
    start_rx();
    start_tx(8'hC3, 1'b0, n);
    wait_hi(tx_err, 12000, n);
    chk_len("underrun delay", 9679, n);
    chk_val("tx underrun error", 8'h01, {7'h0, tx_err});
    chk_val("drive after underrun", 8'h00, {7'h0, tx_drive});
  endtask

  task automatic t_tx_break;
    int n;
    int e0;
    start_rx();
    e0 = n_err;
    start_tx(8'h5A, 1'b1, n);
    u_vpw_bus_node.hold(1'b1, 3000);
    u_vpw_bus_node.hold(1'b0, 10);
    #1;
    chk_len("tx error on break", e0 + 1, n_err);
    chk_val("drive after break", 8'h00, {7'h0, tx_drive});
  endtask

  task automatic t_ifs_start;
    int n;
    start_rx();
    u_vpw_bus_node.hold(1'b1, 100);
    tx_req <= '{valid: 1'b1, data: 8'hC3, last: 1'b1};
    u_vpw_bus_node.hold(1'b1, 1900);
    u_vpw_bus_node.send_byte(8'h3C);
    u_vpw_bus_node.hold(1'b0, 2850);
    #1;
    chk_val("held before separation", 8'h00, {7'h0, tx_drive});
    fork
      u_vpw_bus_node.hold(1'b1, 200);
      wait_hi(tx_take, 100, n);
    join
    chk_val("start on early edge", 8'h01, {7'h0, n < 60});
    @(posedge core_clk);
    tx_req.valid <= 1'b0;
    u_vpw_bus_node.hold(1'b0, 1);
    wait_hi(tx_done, 12000, n);
    chk_val("tx done after resync", 8'h01, {7'h0, tx_done});
    exp_byte(8'h3C);
    exp_q.push_back(vpw_pkg::VPW_SYM_EOD);
    exp_q.push_back(vpw_pkg::VPW_SYM_EOF);
    exp_q.push_back(vpw_pkg::VPW_SYM_IFS);
    exp_q.push_back(vpw_pkg::VPW_SYM_SOF);
    exp_byte(8'hC3);
    tick(40);
    chk_seq();
  endtask

  // ==========================================================
  // Closing report
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    tx_req = '0;
    fast_rx_set = 1'b0;
    invalid_clr = 1'b0;
    t_reset();
    t_rx_frame();
    t_rx_short();
    t_fast_break();
    t_tx_frame();
    t_tx_underrun();
    t_tx_break();
    t_ifs_start();
    stop_test();
  end
endmodule
